// File: hw/ckocfg_regs.v
/*
 * clock output configuration registers: two enable sets, differential
 * level select and the margining feedback divider fields.
 * assumes a serial front end on clk_sys delivering byte writes and reads,
 * and an asynchronous set-select pin from the board.
 */
`timescale 1ns/1ps
`include "ckocfg_map.vh"

// Contract
// (RL1) a set-A enable bit of 0 tri-states its output and 1 enables it; resets 0x8d and 0x33.
// (RL2) a set-B enable bit of 0 tri-states its output and 1 enables it; resets 0x02 and 0xc4.
// (RL3) only the set chosen by the select pin drives the output enables.
// (RL4) three level bits pick low-voltage differential (0) or emitter-coupled (1) for bank A 0..2.
// (RL5) register 6 holds level bits in D7..D5 and set-B bank A enables in D4..D0.
// (RL6) the 7-bit margin integer is the divide value directly, reset 100.
// (RL7) the 9-bit margin fraction adds 19.53125 ppm per step, reset zero.
// (RL8) register 9 holds integer D7..D1 and fraction bit 8 in D0; 10 and 11 hold the rest.
// (RL9) register 3 D4..D0 are set-A bank A; register 5 has bank C high and bank B low; 7 likewise.
// (RL10) writes leave reserved fields unchanged and reserved registers read as zero.
// (RL11) software keeps pump gain, modulator order and dither at their defaults.
// (RL12) fields load defaults on reset and hold written values until next write or reset.
module ckocfg_regs (
    // clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // register access port from the serial front end
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_q,
    // pin-selected enable set, asynchronous
    input  wire        set_b_sel,
    // output enables, high = driving
    output reg  [4:0]  bank_first_oe_q,
    output reg  [3:0]  bank_second_oe_q,
    output reg  [3:0]  bank_third_oe_q,
    // bank A level select
    output reg  [2:0]  diff_level_select_q,
    // margining divider and loop settings
    output reg  [6:0]  margin_divider_integer_q,
    output reg  [8:0]  margin_divider_fraction_q,
    output reg         margin_fraction_ext_bit1_q,
    output reg         margin_fraction_ext_bit2_q,
    output reg         phase_delay_q,
    output reg         pump_gain_select_q,
    output reg  [1:0]  modulator_order_q,
    output reg         dither_en_q
);

    // =================================================================
    // register storage
    wire [7:0] a_en_a_q;
    wire [7:0] bc_en_a_q;
    wire [7:0] a_en_b_q;
    wire [7:0] bc_en_b_q;
    wire [7:0] mgn_int_q;
    wire [7:0] mgn_frac_q;
    wire [7:0] mgn_ext_q;

    // =================================================================
    // write decode; unmapped offsets strobe nothing [RL10]
    wire       wr_a_en_a;
    wire       wr_bc_en_a;
    wire       wr_a_en_b;
    wire       wr_bc_en_b;
    wire       wr_mgn_int;
    wire       wr_mgn_frac;
    wire       wr_mgn_ext;

    assign wr_a_en_a   = reg_wr && (reg_addr == `CKOCFG_OFF_A_EN_A);
    assign wr_bc_en_a  = reg_wr && (reg_addr == `CKOCFG_OFF_BC_EN_A);
    assign wr_a_en_b   = reg_wr && (reg_addr == `CKOCFG_OFF_A_EN_B);
    assign wr_bc_en_b  = reg_wr && (reg_addr == `CKOCFG_OFF_BC_EN_B);
    assign wr_mgn_int  = reg_wr && (reg_addr == `CKOCFG_OFF_MGN_INT);
    assign wr_mgn_frac = reg_wr && (reg_addr == `CKOCFG_OFF_MGN_FRAC_LO);
    assign wr_mgn_ext  = reg_wr && (reg_addr == `CKOCFG_OFF_MGN_EXT);

    ckocfg_reg8 #(.RST_VAL(`CKOCFG_RST_A_EN_A), .WR_MASK(`CKOCFG_WM_A_EN_A)) u_a_en_a (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (wr_a_en_a), // [RL1] [RL9]
        .wr_data (reg_wdata),
        .val_q   (a_en_a_q)
    );
    ckocfg_reg8 #(.RST_VAL(`CKOCFG_RST_BC_EN_A), .WR_MASK(`CKOCFG_WM_FULL)) u_bc_en_a (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (wr_bc_en_a), // [RL1]
        .wr_data (reg_wdata),
        .val_q   (bc_en_a_q)
    );
    ckocfg_reg8 #(.RST_VAL(`CKOCFG_RST_A_EN_B), .WR_MASK(`CKOCFG_WM_FULL)) u_a_en_b (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (wr_a_en_b), // [RL2] [RL5]
        .wr_data (reg_wdata),
        .val_q   (a_en_b_q)
    );
    ckocfg_reg8 #(.RST_VAL(`CKOCFG_RST_BC_EN_B), .WR_MASK(`CKOCFG_WM_FULL)) u_bc_en_b (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (wr_bc_en_b), // [RL2]
        .wr_data (reg_wdata),
        .val_q   (bc_en_b_q)
    );
    ckocfg_reg8 #(.RST_VAL(`CKOCFG_RST_MGN_INT), .WR_MASK(`CKOCFG_WM_FULL)) u_mgn_int (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (wr_mgn_int), // [RL6] [RL8]
        .wr_data (reg_wdata),
        .val_q   (mgn_int_q)
    );
    ckocfg_reg8 #(.RST_VAL(`CKOCFG_RST_MGN_FRAC_LO), .WR_MASK(`CKOCFG_WM_FULL)) u_mgn_frac (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (wr_mgn_frac), // [RL7] [RL8]
        .wr_data (reg_wdata),
        .val_q   (mgn_frac_q)
    );
    ckocfg_reg8 #(.RST_VAL(`CKOCFG_RST_MGN_EXT), .WR_MASK(`CKOCFG_WM_MGN_EXT)) u_mgn_ext (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (wr_mgn_ext), // [RL8] [RL10]
        .wr_data (reg_wdata),
        .val_q   (mgn_ext_q)
    );

    // =================================================================
    // set-select pin synchroniser
    reg set_sel_meta_q;
    reg set_sel_q;

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            set_sel_meta_q <= 1'b0;
            set_sel_q      <= 1'b0;
        end
        else
        begin
            set_sel_meta_q <= set_b_sel;
            set_sel_q      <= set_sel_meta_q;
        end
    end

    // =================================================================
    // read mux; reserved bits read zero, unmapped offsets read zero
    reg [7:0] reg_rdata_d;

    always @*
    begin
        case (reg_addr)
            `CKOCFG_OFF_A_EN_A:     reg_rdata_d = a_en_a_q & `CKOCFG_WM_A_EN_A; // [RL10]
            `CKOCFG_OFF_BC_EN_A:    reg_rdata_d = bc_en_a_q;
            `CKOCFG_OFF_A_EN_B:     reg_rdata_d = a_en_b_q;
            `CKOCFG_OFF_BC_EN_B:    reg_rdata_d = bc_en_b_q;
            `CKOCFG_OFF_MGN_INT:     reg_rdata_d = mgn_int_q;
            `CKOCFG_OFF_MGN_FRAC_LO: reg_rdata_d = mgn_frac_q;
            `CKOCFG_OFF_MGN_EXT:     reg_rdata_d = mgn_ext_q & `CKOCFG_WM_MGN_EXT; // [RL10]
            default:                reg_rdata_d = 8'h00; // [RL10]
        endcase
    end

    // =================================================================
    // read data, reloaded only by a read strobe
    always @(posedge clk_sys)
    begin
        if (sys_rst)
            reg_rdata_q <= 8'h00;
        else
            reg_rdata_q <= reg_rd ? reg_rdata_d : reg_rdata_q; // [RL10] [RL12]
    end

    // =================================================================
    // output enables of the selected set
    // inactive set has no effect; pin change lands after sync delay
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            bank_first_oe_q  <= 5'h00;
            bank_second_oe_q <= 4'h0;
            bank_third_oe_q  <= 4'h0;
        end
        else if (set_sel_q) // [RL3]
        begin
            bank_first_oe_q  <= a_en_b_q[`CKOCFG_BNK1_MSB:`CKOCFG_BNK1_LSB]; // [RL2] [RL5]
            bank_second_oe_q <= bc_en_b_q[`CKOCFG_BNK2_MSB:`CKOCFG_BNK2_LSB]; // [RL2]
            bank_third_oe_q  <= bc_en_b_q[`CKOCFG_BNK3_MSB:`CKOCFG_BNK3_LSB]; // [RL2]
        end
        else
        begin
            bank_first_oe_q  <= a_en_a_q[`CKOCFG_BNK1_MSB:`CKOCFG_BNK1_LSB]; // [RL1] [RL9]
            bank_second_oe_q <= bc_en_a_q[`CKOCFG_BNK2_MSB:`CKOCFG_BNK2_LSB]; // [RL1] [RL9]
            bank_third_oe_q  <= bc_en_a_q[`CKOCFG_BNK3_MSB:`CKOCFG_BNK3_LSB]; // [RL1] [RL9]
        end
    end

    // =================================================================
    // level select and margining divider fields
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            diff_level_select_q        <= 3'h0;
            margin_divider_integer_q   <= 7'h00;
            margin_divider_fraction_q  <= 9'h000;
            margin_fraction_ext_bit1_q <= 1'b0;
            margin_fraction_ext_bit2_q <= 1'b0;
            phase_delay_q              <= 1'b0;
            pump_gain_select_q         <= 1'b0;
            modulator_order_q          <= 2'h0;
            dither_en_q                <= 1'b0;
        end
        else
        begin
            diff_level_select_q <= a_en_b_q[`CKOCFG_LVL_MSB:`CKOCFG_LVL_LSB]; // [RL4] [RL5]
            margin_divider_integer_q <=
                mgn_int_q[`CKOCFG_INT_MSB:`CKOCFG_INT_LSB]; // [RL6] [RL8]
            // ppm offset is linear in this code; analog side scales it
            margin_divider_fraction_q <=
                {mgn_int_q[`CKOCFG_FRAC8_BIT], mgn_frac_q}; // [RL7] [RL8]
            margin_fraction_ext_bit1_q <= mgn_ext_q[`CKOCFG_EXT1_BIT]; // [RL8]
            margin_fraction_ext_bit2_q <= mgn_ext_q[`CKOCFG_EXT2_BIT];
            phase_delay_q              <= mgn_ext_q[`CKOCFG_PDLY_BIT];
            pump_gain_select_q         <= mgn_ext_q[`CKOCFG_PUMP_BIT];
            modulator_order_q          <= mgn_ext_q[`CKOCFG_ORDER_MSB:`CKOCFG_ORDER_LSB];
            dither_en_q                <= mgn_ext_q[`CKOCFG_DITHER_BIT];
        end
    end

endmodule // ckocfg_regs

// File: hw/ckocfg_map.vh
/*
 * register offsets, field positions and reset values of the clock output
 * configuration bank. assumes byte-wide registers on a byte-addressed port.
 */
`ifndef CKOCFG_MAP_VH
`define CKOCFG_MAP_VH

// =====================================================================
// offsets
`define CKOCFG_OFF_A_EN_A      4'h3
`define CKOCFG_OFF_BC_EN_A     4'h5
`define CKOCFG_OFF_A_EN_B      4'h6
`define CKOCFG_OFF_BC_EN_B     4'h7
`define CKOCFG_OFF_MGN_INT     4'h9
`define CKOCFG_OFF_MGN_FRAC_LO 4'ha
`define CKOCFG_OFF_MGN_EXT     4'hb

// =====================================================================
// reset values
`define CKOCFG_RST_A_EN_A      8'h8d
`define CKOCFG_RST_BC_EN_A     8'h33
`define CKOCFG_RST_A_EN_B      8'h02
`define CKOCFG_RST_BC_EN_B     8'hc4
`define CKOCFG_RST_MGN_INT     8'hc8
`define CKOCFG_RST_MGN_FRAC_LO 8'h00
`define CKOCFG_RST_MGN_EXT     8'h10

// =====================================================================
// writable bit masks; zero bits are reserved
`define CKOCFG_WM_A_EN_A       8'hdf
`define CKOCFG_WM_MGN_EXT      8'hdf
`define CKOCFG_WM_FULL         8'hff

// =====================================================================
// field positions
`define CKOCFG_LVL_MSB         7
`define CKOCFG_LVL_LSB         5
`define CKOCFG_BNK1_MSB        4
`define CKOCFG_BNK1_LSB        0
`define CKOCFG_BNK3_MSB        7
`define CKOCFG_BNK3_LSB        4
`define CKOCFG_BNK2_MSB        3
`define CKOCFG_BNK2_LSB        0
`define CKOCFG_INT_MSB         7
`define CKOCFG_INT_LSB         1
`define CKOCFG_FRAC8_BIT       0
`define CKOCFG_EXT1_BIT        7
`define CKOCFG_EXT2_BIT        6
`define CKOCFG_PDLY_BIT        4
`define CKOCFG_PUMP_BIT        3
`define CKOCFG_ORDER_MSB       2
`define CKOCFG_ORDER_LSB       1
`define CKOCFG_DITHER_BIT      0

`endif

// File: hw/ckocfg_reg8.v
/*
 * one byte-wide configuration register with a reset value and a writable
 * mask. assumes write strobe and data are on the clk_sys domain.
 */
`timescale 1ns/1ps

module ckocfg_reg8 #(
    parameter [7:0] RST_VAL = 8'h00,
    parameter [7:0] WR_MASK = 8'hff
) (
    // clock and reset
    input  wire       clk_sys,
    input  wire       sys_rst,
    // write port
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    // stored value
    output reg  [7:0] val_q
);

    wire [7:0] val_d;

    // reserved bits keep their value on writes; no write holds all bits
    assign val_d = wr_en ? ((wr_data & WR_MASK) | (val_q & ~WR_MASK)) : val_q; // [RL10] [RL12]

    always @(posedge clk_sys)
    begin
        if (sys_rst)
            val_q <= RST_VAL; // [RL12]
        else
            val_q <= val_d; // [RL12]
    end

endmodule // ckocfg_reg8

// File: testbench/ckocfg_regs_sva.sv
/* checker for the clock output configuration bank ports.
   assumes a bind onto ckocfg_regs and one clock domain. */
`timescale 1ns/1ps
module ckocfg_regs_sva (
    // clock and reset
    input logic       clk_sys,
    input logic       sys_rst,
    // register port and set pin
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata_q,
    input logic       set_b_sel,
    // outputs
    input logic [4:0] bank_first_oe_q,
    input logic [3:0] bank_second_oe_q,
    input logic [3:0] bank_third_oe_q,
    input logic [2:0] diff_level_select_q,
    input logic [6:0] margin_divider_integer_q,
    input logic [8:0] margin_divider_fraction_q
);
    // ========
    // helpers: pin history spans the sync path
    logic [15:0] wa;
    logic [3:0]  pin_h_q;
    logic [7:0]  wd1_q, wd2_q;
    wire         unm = !(reg_addr inside {4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb});
    assign wa = reg_wr ? (16'h0001 << reg_addr) : 16'h0000;
    always @(posedge clk_sys)
    begin
        pin_h_q <= {pin_h_q[2:0], set_b_sel};
        wd1_q   <= reg_wdata;
        wd2_q   <= wd1_q;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ========
    // assertions
    a_unmapped_read_zero: assert property (reg_rd && unm |=> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_q))
        else $error("read data moved");
    a_reserved_bit_zero: assert property (reg_rd && reg_addr == 4'h3 |=> !reg_rdata_q[5])
        else $error("reserved bit set");
    a_level_follows: assert property (wa[6] |-> ##2 diff_level_select_q == wd2_q[7:5])
        else $error("level select wrong");
    a_integer_follows:
        assert property (wa[9] |-> ##2
            {margin_divider_integer_q, margin_divider_fraction_q[8]} == wd2_q)
        else $error("integer divider wrong");
    a_fraction_low: assert property (wa[10] |-> ##2 margin_divider_fraction_q[7:0] == wd2_q)
        else $error("fraction wrong");
    a_set_a_first:
        assert property (wa[3] && pin_h_q == 4'h0 && !set_b_sel ##2 pin_h_q == 4'h0
            |-> bank_first_oe_q == wd2_q[4:0]) else $error("set a bank a wrong");
    a_set_b_banks:
        assert property (wa[7] && pin_h_q == 4'hf && set_b_sel ##2 pin_h_q == 4'hf
            |-> {bank_third_oe_q, bank_second_oe_q} == wd2_q) else $error("set b banks wrong");
    c_write_set_a: cover property (wa[3] && !set_b_sel);
    c_write_set_b: cover property (wa[7] && set_b_sel);
    c_unmapped_read: cover property (reg_rd && unm);
endmodule // ckocfg_regs_sva

bind ckocfg_regs ckocfg_regs_sva i_ckocfg_regs_sva (.clk_sys, .sys_rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata_q, .set_b_sel, .bank_first_oe_q, .bank_second_oe_q,
    .bank_third_oe_q, .diff_level_select_q, .margin_divider_integer_q,
    .margin_divider_fraction_q);

// File: testbench/ckocfg_host.sv
/* host model for the register port.
   assumes calls only outside reset. */
`timescale 1ns/1ps
module ckocfg_host (
    // clock
    input  logic       clk_sys,
    // register port
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
    // ========
    // one strobe per byte; released data shows its inverse
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk_sys);
        {reg_wr, reg_rd, reg_wdata} <= {2'h0, ~d};
    endtask
endmodule // ckocfg_host

// File: testbench/ckocfg_regs_tb.sv
/* self-checking bench for the clock output configuration bank.
   assumes host model and checker compiled first. */
`timescale 1ns/1ps
module ckocfg_regs_tb;
    // ========
    // signals and expected model
    localparam logic [7:0] RV [16] = '{8'h00, 8'h00, 8'h00, 8'h8d, 8'h00, 8'h33, 8'h02, 8'hc4,
                                       8'h00, 8'hc8, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    logic       clk_sys, rd_d = 1'b0, sys_rst = 1'b1, set_b_sel = 1'b0;
    wire        reg_wr, reg_rd, margin_fraction_ext_bit1_q, margin_fraction_ext_bit2_q;
    wire        phase_delay_q, pump_gain_select_q, dither_en_q;
    wire [1:0]  modulator_order_q;
    wire [2:0]  diff_level_select_q;
    wire [3:0]  reg_addr, bank_second_oe_q, bank_third_oe_q;
    wire [4:0]  bank_first_oe_q;
    wire [6:0]  margin_divider_integer_q;
    wire [7:0]  reg_wdata, reg_rdata_q;
    wire [8:0]  margin_divider_fraction_q;
    logic [7:0] m [16];
    logic [7:0] q [$];
    int         fails = 0, n_checks = 0, cyc = 0, seed = 33421;
    ckocfg_regs i_ckocfg_regs (.clk_sys, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata_q, .set_b_sel, .bank_first_oe_q, .bank_second_oe_q, .bank_third_oe_q,
        .diff_level_select_q, .margin_divider_integer_q, .margin_divider_fraction_q,
        .margin_fraction_ext_bit1_q, .margin_fraction_ext_bit2_q, .phase_delay_q,
        .pump_gain_select_q, .modulator_order_q, .dither_en_q);
    ckocfg_host i_ckocfg_host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    // ========
    // tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_ckocfg_host.xfer(1'b1, a, d);
        if (a inside {3, 5, 6, 7, 9, 10, 11})
            m[a] = (a == 3 || a == 11) ? d & 8'hdf : d;
    endtask
    task automatic rd(input logic [3:0] a);
        q.push_back(m[a]);
        i_ckocfg_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic outs(input logic s);
        set_b_sel <= s;
        repeat (4) @(posedge clk_sys);
        chk("bank a", s ? m[6][4:0] : m[3][4:0], bank_first_oe_q);
        chk("banks b c", s ? m[7] : m[5], {bank_third_oe_q, bank_second_oe_q});
        chk("level", m[6][7:5], diff_level_select_q);
        chk("margin", {m[9], m[10]},
            {margin_divider_integer_q, margin_divider_fraction_q});
        chk("loop", {m[11][7:6], m[11][4:0]}, {margin_fraction_ext_bit1_q,
            margin_fraction_ext_bit2_q, phase_delay_q, pump_gain_select_q, modulator_order_q,
            dither_en_q});
    endtask
    // ========
    // clock, read monitor and hang limit
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (rd_d)
            chk("read data", q.pop_front(), reg_rdata_q);
        rd_d <= reg_rd;
        cyc  <= cyc + 1;
        if (cyc == 3000)
        begin
            fails++;
            conclude();
        end
    end
    // ========
    // main sequence: each pass starts with a reset and reloads defaults
    initial
    begin
        for (int it = 0; it < 8; it++)
        begin
            sys_rst <= 1'b1;
            repeat (3) @(posedge clk_sys);
            sys_rst <= 1'b0;
            m = RV;
            for (int a = 0; a < 16; a++)
                rd(a[3:0]);
            outs(1'b0);
            outs(1'b1);
            set_b_sel <= it[0];
            for (int a = 0; a < 16; a++)
                wr(a[3:0], a == 11 ? 8'($random(seed)) & 8'hf0 : 8'($random(seed)));
            for (int a = 0; a < 16; a++)
                rd(a[3:0]);
            outs(1'b0);
            outs(1'b1);
        end
        conclude();
    end
endmodule // ckocfg_regs_tb
